// ===== pkg/apc_regs.svh
// Constants for the auxiliary serial PCM codec port.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef APC_REGS_SVH
`define APC_REGS_SVH

`define APC_WORD_BITS 16
`define APC_FIFO_DEPTH 8
`define APC_CLK_PERIOD_NS 10
`define APC_SAMPLE_PERIOD_NS 125000
`define APC_SAMPLE_CYCLES (`APC_SAMPLE_PERIOD_NS / `APC_CLK_PERIOD_NS)
`define APC_RESET_MIN_NS 100
`define APC_BITCNT_DONE 5'h10

`define APC_CFG_OFF 4'h0
`define APC_CFG_CODEC 4'h1
`define APC_CFG_XCVR 4'h2
`define APC_CFG_SHARED 4'h3

`endif

// ===== pkg/apc_pkg.sv
// Types for the auxiliary serial PCM codec port.
// Assumes apc_regs.svh supplies the numeric constants.
package apc_pkg;
  typedef enum logic [3:0] {
    APC_IDLE   = 4'h1,
    APC_CODEC  = 4'h2,
    APC_XCVR   = 4'h4,
    APC_FINISH = 4'h8
  } apc_state_t;
endpackage

// ===== pkg/apc_stream_if.sv
// Valid/ready word stream between the port logic and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface apc_stream_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== design/apc_fifo.sv
// Word FIFO held in flip-flops, valid/ready on both sides.
// Assumes synchronous active-low reset; DEPTH a power of two.
`timescale 1ns/1ps
module apc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,        // System clock
  input wire logic resetn,     // Synchronous reset, active low
  apc_stream_if.snk pushSide,  // Filling side
  apc_stream_if.src popSide    // Draining side
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic inReady_reg;
  logic push;
  logic pop;

  assign push = pushSide.valid && inReady_reg;
  assign pop = popSide.ready && (count_reg != '0);
  assign pushSide.ready = inReady_reg;
  assign popSide.valid = (count_reg != '0);
  assign popSide.data = mem[rdPtr_reg];

  always_comb
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      always_ff @(posedge clk)
      begin
        if (push && wrPtr_reg == AW'(i))
          mem[i] <= pushSide.data;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady_reg <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop)
        rdPtr_reg <= rdPtr_reg + 1'b1;
      count_reg <= count_next;
      // Registered so the source sees full without a combinational path
      inReady_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule

// ===== design/apc_port.sv
// Auxiliary serial port: PCM codec stream plus transceiver pass-through.
// Assumes the far side supplies the shift clock on the pins, idle low between words.
`timescale 1ns/1ps
`include "apc_regs.svh"

// Functional notes
// - Transceiver and codec share clock and data, each with its own select.
// - Reset returns everything, serial port included, to power-on state.
// - One protocol active; host writes its four-bit select field.
// - Port operating mode comes from four host-written configuration bits.
// - Codec mode carries 16-bit PCM samples at 8 ksps each way.
// - Transmit samples are lowpass filtered then shifted out toward the vocoder.
// - Received samples are shifted in, filtered, then attenuated to the output.
// - With quadrature receive, transceiver traffic shares the port on its own select.
// - Host words pass through to transceiver registers over the shared port.
module apc_port #(
  parameter int unsigned SAMPLE_CYCLES = `APC_SAMPLE_CYCLES
) (
  input wire logic clk,                 // 100 MHz system clock
  input wire logic resetn,              // Synchronous reset, active low
  input wire logic [3:0] portConfig,    // Port configuration block bits
  input wire logic [3:0] protocolConfig, // Protocol select field
  input wire logic protocolWrite,       // Strobe loading protocolConfig
  input wire logic quadMode,            // Quadrature receive selected
  input wire logic [2:0] audioAtten,    // Output attenuation, 6 dB steps
  input wire logic [15:0] txSample,     // Microphone PCM sample
  input wire logic txValid,             // txSample offered
  output logic txReady,                 // FIFO can take txSample
  output logic [15:0] rxSample,         // Filtered, attenuated audio
  output logic rxValid,                 // One-cycle pulse with rxSample
  input wire logic [15:0] xcvrWord,     // Pass-through word for transceiver
  input wire logic xcvrValid,           // xcvrWord offered
  output logic xcvrReady,               // Pass-through word can be taken
  output logic [3:0] activeProtocol,    // Protocol in force
  input wire logic auxPortShiftClock,   // Shift clock from far side
  input wire logic auxPortSerialIn,     // Serial data from vocoder
  output logic auxPortSerialOut,        // Serial data to vocoder or transceiver
  output logic auxPortSelectN,          // Transceiver select, active low
  output logic codecSelectOutN          // Codec select, active low
);
  localparam logic [13:0] FRAME_LAST = 14'(SAMPLE_CYCLES - 1);

  apc_pkg::apc_state_t state_reg;
  apc_stream_if #(.WIDTH(`APC_WORD_BITS)) txIn ();
  apc_stream_if #(.WIDTH(`APC_WORD_BITS)) txOut ();

  logic sclkS1, sclkS2, sclkS3;
  logic sinS1, sinS2;
  logic sclkRise, sclkFall;
  logic [3:0] cfg_reg;
  logic quad_reg;
  logic [13:0] frameCnt_reg;
  logic frameTick;
  logic framePend_reg;
  logic [15:0] txPrev_reg;
  logic [15:0] rxPrev_reg;
  logic [15:0] shiftOut_reg;
  logic [15:0] shiftIn_reg;
  logic [4:0] bitCnt_reg;
  logic [15:0] xcvrPend_reg;
  logic xcvrHave_reg;
  logic codecOn, xcvrOn;
  logic startCodec, startXcvr;
  logic [16:0] txSum;
  logic [16:0] rxSum;
  logic [15:0] rxFilt;

  // Link clock and data cross into clk domain through two flops
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sclkS1 <= 1'b0;
      sclkS2 <= 1'b0;
      sclkS3 <= 1'b0;
      sinS1 <= 1'b0;
      sinS2 <= 1'b0;
    end
    else
    begin
      sclkS1 <= auxPortShiftClock;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
      sinS1 <= auxPortSerialIn;
      sinS2 <= sinS1;
    end
  end

  assign sclkRise = sclkS2 && !sclkS3;
  assign sclkFall = !sclkS2 && sclkS3;

  // Mode bits only change between words so a frame never tears
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cfg_reg <= `APC_CFG_OFF;
      quad_reg <= 1'b0;
    end
    else if (state_reg == apc_pkg::APC_IDLE)
    begin
      cfg_reg <= portConfig;
      quad_reg <= quadMode;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      activeProtocol <= 4'h0;
    else if (protocolWrite)
      activeProtocol <= protocolConfig;
  end

  assign codecOn = (cfg_reg == `APC_CFG_CODEC) || (cfg_reg == `APC_CFG_SHARED);
  assign xcvrOn = (cfg_reg == `APC_CFG_XCVR) || ((cfg_reg == `APC_CFG_SHARED) && quad_reg);

  // Sample period timer
  assign frameTick = (frameCnt_reg == 14'h0000);

  always_ff @(posedge clk)
  begin
    if (!resetn)
      frameCnt_reg <= FRAME_LAST;
    else if (frameTick)
      frameCnt_reg <= FRAME_LAST;
    else
      frameCnt_reg <= frameCnt_reg - 14'h0001;
  end

  // Set wins over the clear taken when a frame starts
  always_ff @(posedge clk)
  begin
    if (!resetn)
      framePend_reg <= 1'b0;
    else if (frameTick && codecOn)
      framePend_reg <= 1'b1;
    else if (startCodec || !codecOn)
      framePend_reg <= 1'b0;
  end

  // Two-tap lowpass on the microphone path ahead of the FIFO
  assign txSum = {txSample[15], txSample} + {txPrev_reg[15], txPrev_reg};
  assign txIn.valid = txValid;
  assign txIn.data = txSum[16:1];
  assign txReady = txIn.ready;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      txPrev_reg <= 16'h0000;
    else if (txValid && txIn.ready)
      txPrev_reg <= txSample;
  end

  apc_fifo #(.WIDTH(`APC_WORD_BITS), .DEPTH(`APC_FIFO_DEPTH)) uTxFifo (
    .clk(clk),
    .resetn(resetn),
    .pushSide(txIn),
    .popSide(txOut)
  );

  // Codec frames take precedence over pass-through words
  assign startCodec = (state_reg == apc_pkg::APC_IDLE) && framePend_reg && codecOn;
  assign startXcvr = (state_reg == apc_pkg::APC_IDLE) && !framePend_reg && xcvrHave_reg && xcvrOn;
  assign txOut.ready = startCodec;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      xcvrHave_reg <= 1'b0;
      xcvrPend_reg <= 16'h0000;
      xcvrReady <= 1'b0;
    end
    else
    begin
      if (xcvrValid && xcvrReady)
      begin
        xcvrHave_reg <= 1'b1;
        xcvrPend_reg <= xcvrWord;
        xcvrReady <= 1'b0;
      end
      else if (startXcvr)
      begin
        xcvrHave_reg <= 1'b0;
        xcvrReady <= 1'b1;
      end
      else
        xcvrReady <= !xcvrHave_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_reg <= apc_pkg::APC_IDLE;
    else
    begin
      unique case (state_reg)
        apc_pkg::APC_IDLE:
          if (startCodec)
            state_reg <= apc_pkg::APC_CODEC;
          else if (startXcvr)
            state_reg <= apc_pkg::APC_XCVR;
        apc_pkg::APC_CODEC, apc_pkg::APC_XCVR:
          if (bitCnt_reg == `APC_BITCNT_DONE)
            state_reg <= apc_pkg::APC_FINISH;
        apc_pkg::APC_FINISH:
          state_reg <= apc_pkg::APC_IDLE;
      endcase
    end
  end

  // Bits change on falling shift-clock edges, sampled on rising ones
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      shiftOut_reg <= 16'h0000;
      shiftIn_reg <= 16'h0000;
      bitCnt_reg <= 5'h00;
    end
    else if (startCodec)
    begin
      // An empty FIFO sends silence rather than stalling the frame
      shiftOut_reg <= txOut.valid ? txOut.data : 16'h0000;
      bitCnt_reg <= 5'h00;
    end
    else if (startXcvr)
    begin
      shiftOut_reg <= xcvrPend_reg;
      bitCnt_reg <= 5'h00;
    end
    else if (state_reg == apc_pkg::APC_CODEC || state_reg == apc_pkg::APC_XCVR)
    begin
      if (sclkRise && bitCnt_reg != `APC_BITCNT_DONE)
      begin
        shiftIn_reg <= {shiftIn_reg[14:0], sinS2};
        bitCnt_reg <= bitCnt_reg + 5'h01;
      end
      if (sclkFall && bitCnt_reg != 5'h00)
        shiftOut_reg <= {shiftOut_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      codecSelectOutN <= 1'b1;
      auxPortSelectN <= 1'b1;
      auxPortSerialOut <= 1'b0;
    end
    else
    begin
      codecSelectOutN <= !(startCodec || (state_reg == apc_pkg::APC_CODEC));
      auxPortSelectN <= !(startXcvr || (state_reg == apc_pkg::APC_XCVR));
      if (state_reg == apc_pkg::APC_CODEC || state_reg == apc_pkg::APC_XCVR)
        auxPortSerialOut <= shiftOut_reg[15];
      else
        auxPortSerialOut <= 1'b0;
    end
  end

  // Receive filter and attenuator
  assign rxSum = {shiftIn_reg[15], shiftIn_reg} + {rxPrev_reg[15], rxPrev_reg};
  assign rxFilt = rxSum[16:1];

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rxPrev_reg <= 16'h0000;
      rxSample <= 16'h0000;
      rxValid <= 1'b0;
    end
    else
    begin
      rxValid <= 1'b0;
      if (state_reg == apc_pkg::APC_FINISH && !codecSelectOutN)
      begin
        rxPrev_reg <= shiftIn_reg;
        rxSample <= 16'($signed(rxFilt) >>> audioAtten);
        rxValid <= 1'b1;
      end
    end
  end

  property p_selExclusive;
    @(posedge clk) disable iff (!resetn)
    !(!codecSelectOutN && !auxPortSelectN);
  endproperty
  a_selExclusive: assert property (p_selExclusive) else $error("both selects low");

  property p_resetIdle;
    @(posedge clk)
    !resetn |=> (state_reg == apc_pkg::APC_IDLE) && codecSelectOutN && auxPortSelectN && !rxValid;
  endproperty
  a_resetIdle: assert property (p_resetIdle) else $error("reset did not reinitialise port");

  property p_protoHeld;
    @(posedge clk) disable iff (!resetn)
    !protocolWrite |=> $stable(activeProtocol);
  endproperty
  a_protoHeld: assert property (p_protoHeld) else $error("protocol changed without write");

  property p_offSilent;
    @(posedge clk) disable iff (!resetn)
    (cfg_reg == `APC_CFG_OFF) && (state_reg == apc_pkg::APC_IDLE) |=> codecSelectOutN && auxPortSelectN;
  endproperty
  a_offSilent: assert property (p_offSilent) else $error("port active while disabled");

  property p_frameReload;
    @(posedge clk) disable iff (!resetn)
    frameTick |=> (frameCnt_reg == FRAME_LAST) ##1 (frameCnt_reg == FRAME_LAST - 14'h0001);
  endproperty
  a_frameReload: assert property (p_frameReload) else $error("sample period not kept");

  property p_msbFirst;
    @(posedge clk) disable iff (!resetn)
    startCodec && txOut.valid |=> ##1 (auxPortSerialOut == $past(txOut.data[15], 2));
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("first bit not sample MSB");

  property p_rxDeliver;
    @(posedge clk) disable iff (!resetn)
    (state_reg == apc_pkg::APC_FINISH) && !codecSelectOutN |=> rxValid ##1 !rxValid;
  endproperty
  a_rxDeliver: assert property (p_rxDeliver) else $error("received sample not delivered");

  property p_xcvrGated;
    @(posedge clk) disable iff (!resetn)
    $fell(auxPortSelectN) |-> $past(xcvrOn);
  endproperty
  a_xcvrGated: assert property (p_xcvrGated) else $error("transceiver select outside allowed mode");

  property p_sixteenBits;
    @(posedge clk) disable iff (!resetn)
    (state_reg == apc_pkg::APC_FINISH) |-> (bitCnt_reg == `APC_BITCNT_DONE) && $past(codecSelectOutN && auxPortSelectN, 1) == 1'b0;
  endproperty
  a_sixteenBits: assert property (p_sixteenBits) else $error("word not 16 bits in one select");
endmodule

// ===== tb/apc_far_model.sv
// Far-side model: vocoder and transceiver on the shared auxiliary port.
// Assumes the block drives MSB first; shift clock runs only inside frames.
`timescale 1ns/1ps
module apc_far_model (
  input wire logic codecSelN, // Codec select from block
  input wire logic xcvrSelN, // Transceiver select from block
  input wire logic serialFromDut, // Data toward the far side
  input wire logic [15:0] sendWord, // Word the vocoder returns next
  output logic shiftClock, // Shift clock, still between frames
  output logic serialToDut, // Data from vocoder
  output logic [15:0] gotWord, // Last whole word captured
  output logic gotCodec, // Last word came under codec select
  output int frames // Whole words captured
);
  logic [15:0] shiftOut;
  logic [15:0] shiftIn;
  logic onCodec;
  int bitNum;

  initial
  begin
    shiftClock = 1'b0;
    serialToDut = 1'b0;
    gotWord = 16'h0000;
    gotCodec = 1'b0;
    frames = 0;
    forever
    begin
      wait (!codecSelN || !xcvrSelN);
      onCodec = !codecSelN;
      shiftOut = sendWord;
      serialToDut = shiftOut[15];
      // Select dropped mid-word means a reset: abandon the word
      for (bitNum = 0; bitNum < 16 && !(codecSelN && xcvrSelN); bitNum++)
      begin
        #62.5;
        shiftClock = 1'b1;
        shiftIn = {shiftIn[14:0], serialFromDut};
        #62.5;
        shiftClock = 1'b0;
        shiftOut = {shiftOut[14:0], 1'b0};
        // Released line shows the inverse, never a stale bit
        serialToDut = (bitNum == 15) ? ~serialToDut : shiftOut[15];
      end
      if (bitNum == 16)
      begin
        gotWord = shiftIn;
        gotCodec = onCodec;
        frames++;
      end
      // Watch only our own select; the other may already be falling
      wait (onCodec ? codecSelN : xcvrSelN);
    end
  end
endmodule

// ===== tb/aux_serial_pcm_codec_port_test.sv
// Self-checking bench for the auxiliary serial PCM codec port.
// Assumes apc_far_model stands on the pins; short sample period for speed.
`timescale 1ns/1ps
module aux_serial_pcm_codec_port_test;
  localparam int SC = 400;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] portConfig = 4'h0;
  logic [3:0] protocolConfig = 4'h0;
  logic protocolWrite = 1'b0;
  logic quadMode = 1'b0;
  logic [2:0] audioAtten = 3'h0;
  logic [15:0] txSample = 16'h0000;
  logic txValid = 1'b0;
  logic [15:0] xcvrWord = 16'h0000;
  logic xcvrValid = 1'b0;
  logic [15:0] sendWord = 16'h0000;
  logic txReady, rxValid, xcvrReady, shiftClock, serialIn, serialOut, xcvrSelN, codecSelN, gotCodec;
  logic [15:0] rxSample, gotWord;
  logic [3:0] activeProtocol;
  int frames, mismatches = 0, checkCount = 0, gap = 0;
  logic gapOn = 1'b0, gapArmed = 1'b0, selPrev = 1'b1;
  logic [15:0] txq[$], rxq[$], txPrev = 16'h0000, rxPrev = 16'h0000;

  always #5 clk = ~clk;

  apc_port #(.SAMPLE_CYCLES(SC)) dut (.clk(clk), .resetn(resetn), .portConfig(portConfig),
    .protocolConfig(protocolConfig), .protocolWrite(protocolWrite), .quadMode(quadMode),
    .audioAtten(audioAtten), .txSample(txSample), .txValid(txValid), .txReady(txReady),
    .rxSample(rxSample), .rxValid(rxValid), .xcvrWord(xcvrWord), .xcvrValid(xcvrValid),
    .xcvrReady(xcvrReady), .activeProtocol(activeProtocol), .auxPortShiftClock(shiftClock),
    .auxPortSerialIn(serialIn), .auxPortSerialOut(serialOut), .auxPortSelectN(xcvrSelN),
    .codecSelectOutN(codecSelN));

  apc_far_model far (.codecSelN(codecSelN), .xcvrSelN(xcvrSelN), .serialFromDut(serialOut),
    .sendWord(sendWord), .shiftClock(shiftClock), .serialToDut(serialIn), .gotWord(gotWord),
    .gotCodec(gotCodec), .frames(frames));

  // Two-tap average, sign kept through the carry bit
  function automatic logic [15:0] avg2(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {a[15], a} + {b[15], b};
    return s[16:1];
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stopTest();
    if (mismatches == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic pushWords(input int n);
    logic [15:0] w;
    for (int i = 0; i < n; i++)
    begin
      w = (i < 2) ? (i ? 16'h7FFF : 16'h8000) : 16'($urandom);
      txSample <= w;
      txValid <= 1'b1;
      do @(posedge clk); while (txReady !== 1'b1);
      txq.push_back(avg2(w, txPrev));
      txPrev = w;
    end
    txValid <= 1'b0;
  endtask

  task automatic sendXcvr(input logic [15:0] w);
    xcvrWord <= w;
    xcvrValid <= 1'b1;
    do @(posedge clk); while (xcvrReady !== 1'b1);
    xcvrValid <= 1'b0;
    @(posedge clk);
    check("xcvr ready while word held", xcvrReady, 1'b0);
  endtask

  task automatic waitFrame();
    int n;
    n = frames;
    for (int k = 0; k < 1000 && frames == n; k++) @(posedge clk);
    check("frame count", 16'(frames), 16'(n + 1));
  endtask

  always @(negedge codecSelN) rxq.push_back(sendWord);

  always @(posedge clk)
  begin
    if (resetn && rxValid)
    begin
      check("rx sample", rxSample, 16'($signed(avg2(rxq[0], rxPrev)) >>> audioAtten));
      rxPrev = rxq.pop_front();
      sendWord <= 16'($urandom);
    end
    gap <= gap + 1;
    if (selPrev && !codecSelN)
    begin
      if (gapOn && gapArmed) check("frame spacing", 16'(gap > SC - 2 && gap < SC + 2), 16'h0001);
      gapArmed <= gapOn;
      gap <= 1;
    end
    selPrev <= codecSelN;
  end

  initial
  begin
    #500000;
    mismatches++;
    stopTest();
  end

  initial
  begin
    logic [15:0] xw;
    void'($urandom(32'h4697));
    repeat (12) @(posedge clk);
    check("ready in reset", txReady, 1'b0);
    check("codec select in reset", codecSelN, 1'b1);
    check("xcvr ready in reset", xcvrReady, 1'b0);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      protocolConfig <= 4'($urandom);
      protocolWrite <= 1'b1;
      @(posedge clk);
      protocolWrite <= 1'b0;
      @(posedge clk);
      check("active protocol", activeProtocol, protocolConfig);
    end
    audioAtten <= 3'($urandom);
    // Port off: nothing drains, so the FIFO must refuse after eight
    pushWords(8);
    repeat (2) @(posedge clk);
    check("ready when full", txReady, 1'b0);
    portConfig <= 4'h1;
    gapOn = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      if (i == 9) pushWords(2);
      waitFrame();
      check("codec word", gotWord, (txq.size() > 0) ? txq.pop_front() : 16'h0000);
      check("codec select used", gotCodec, 1'b1);
      check("rx words delivered", 16'(rxq.size()), 16'h0000);
    end
    gapOn = 1'b0;
    portConfig <= 4'h3;
    quadMode <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1) portConfig <= 4'h2;
      xw = 16'($urandom);
      sendXcvr(xw);
      for (int k = 0; k < 4; k++)
      begin
        waitFrame();
        if (gotCodec === 1'b0) break;
      end
      check("pass-through word", gotWord, xw);
      check("transceiver select used", gotCodec, 1'b0);
    end
    portConfig <= 4'h1;
    for (int k = 0; k < 1000 && codecSelN !== 1'b0; k++) @(posedge clk);
    repeat (40) @(posedge clk);
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    check("selects after reset", {codecSelN, xcvrSelN}, 2'b11);
    check("serial out after reset", serialOut, 1'b0);
    check("protocol after reset", activeProtocol, 4'h0);
    rxq.delete();
    txq.delete();
    txPrev = 16'h0000;
    rxPrev = 16'h0000;
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    pushWords(1);
    waitFrame();
    check("word after reset", gotWord, txq.pop_front());
    repeat (5) @(posedge clk);
    stopTest();
  end
endmodule
